//--- hdl/fcu_control_unit.v
// control command interpreter for a floppy disk controller
`timescale 1ns/10ps
//
// Summary of operation
// - drive status answers immediately with status 3
// - head unload delay set by head_unload_time
// - step spacing set by step_rate_time
// - head load wait n*0.5ms, zero means 64ms
// - unload n*4ms, step (16-n)*0.25ms, rate scaled
// - delays follow rate only, not recording mode
// - no_dma_select one selects non-dma mode
// - dma request versus request_for_master and interrupt
// - configure optional, reset gives documented defaults
// - implied seek enable requests seek before transfer
// - fifo_disable_bit set means byte-by-byte requests
// - polling gives one interrupt, held off while head loaded
// - fifo_threshold is value plus one bytes
// - precomp_start_track coded directly 0 to 255
// - version query returns one fixed byte
// - relative seek reuses seek layout plus bits
// - direction zero steps out, one steps in
// - relative seek issues count step pulses unless an outward one reaches track zero
// - only one relative seek active at once
// - relative seek stepping out past track zero sets fault
// - present_cylinder wraps modulo 256
// - recalibrate watches track zero, 80 steps max
// - seek end raises interrupt, sense clears it
`include "fcu_defines.vh"

module fcu_control_unit #(
  parameter TICK_CYC   = `FCU_TICK_CYC,
  parameter [7:0] VERSION_BYTE = 8'h5a  // arbitrary identity value
) (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire        i_ce,
  input  wire [3:0]  i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [7:0]  o_rdata,
  input  wire [1:0]  i_rate_sel,        // 0=2M 1=1M 2=500K 3=250K
  input  wire        i_track_zero_sense,
  input  wire        i_write_prot,
  input  wire        i_xfer_done,       // end of a read/write execution phase
  input  wire        i_xfer_need,       // data transfer wanted by datapath
  output reg         o_step,
  output reg         o_step_dir,
  output reg         o_head_load,
  output wire        o_head_ready,
  output wire        o_dma_req,
  output wire        o_request_for_master,
  output wire        o_irq,
  output wire        o_implied_seek_enable,
  output wire        o_fifo_disable_bit,
  output wire [4:0]  o_fifo_threshold_bytes,
  output wire [7:0]  o_precomp_start_track,
  output wire        o_busy
);

  // --------------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------------
  localparam [5:0] S_IDLE  = 6'b000001;  // waiting for opcode
  localparam [5:0] S_PARAM = 6'b000010;  // collecting parameter bytes
  localparam [5:0] S_EXEC  = 6'b000100;  // launching the command
  localparam [5:0] S_STEP  = 6'b001000;  // step pulse high
  localparam [5:0] S_GAP   = 6'b010000;  // spacing between steps
  localparam [5:0] S_DONE  = 6'b100000;  // finishing a seek

  reg  [5:0]  state_q;                   // controller state
  reg  [7:0]  op_q;                      // opcode byte held
  reg  [1:0]  pcnt_q;                    // parameter bytes still expected
  reg  [1:0]  pidx_q;                    // parameter byte index
  reg  [7:0]  p1_q;                      // first parameter byte
  reg  [7:0]  p2_q;                      // second parameter byte
  reg  [7:0]  p3_q;                      // third parameter byte
  reg  [3:0]  srt_q;                     // step_rate_time
  reg  [3:0]  hut_q;                     // head_unload_time
  reg  [6:0]  hlt_q;                     // head_load_time
  reg         no_dma_q;                  // no_dma_select
  reg         eis_q;                     // implied_seek_enable
  reg         fifo_disable_bit_q;                   // fifo_disable_bit
  reg         poll_off_q;                // drive_status_sweep_off
  reg  [3:0]  thr_q;                     // fifo_threshold
  reg  [7:0]  precomp_start_track_q;                  // precomp_start_track
  reg  [7:0]  pcn_q;                     // present_cylinder
  reg  [7:0]  steps_q;                   // steps remaining
  reg         recal_q;                   // current seek is a recalibrate
  reg         rel_q;                     // relative seek active
  reg  [7:0]  st0_q;                     // status 0 for sense interrupt
  reg         irq_q;                     // interrupt pending
  reg         poll_done_q;               // post-reset poll interrupt given
  reg  [7:0]  res_q;                     // result byte
  reg         res_v_q;                   // result byte waiting
  reg  [15:0] tick_q;                    // prescaler to 0.25 ms ticks
  reg  [11:0] dly_q;                     // step spacing in ticks
  reg  [11:0] hld_q;                     // head load countdown
  reg  [11:0] hut_cnt_q;                 // head unload countdown
  reg  [7:0]  pw_q;                      // step pulse width cycles
  reg         xfer_q;                    // a transfer request is pending

  wire        tick = (tick_q == 16'h0000);
  wire [4:0]  opc  = op_q[4:0];
  wire        cmd_wr = i_wr && (i_addr == `FCU_ADDR_CMD);

  // --------------------------------------------------------------------------
  // data-rate scaling of delays
  // --------------------------------------------------------------------------
  // shift amount: 2M=0, 1M=1, 500K=2, 250K=3 (eight times slower)
  function [11:0] scale;
    input [11:0] v;
    input [1:0]  r;
    begin
      scale = v << r;
    end
  endfunction

  // step spacing in ticks: (16-n)
  wire [11:0] srt_ticks = scale({7'h00, (5'h10 - {1'b0, srt_q})}, i_rate_sel);
  // head load: n*0.5ms = 2n ticks, zero gives 64ms = 256 ticks
  wire [11:0] hlt_ticks = scale((hlt_q == 7'h00) ? 12'h100 :
                                {4'h0, hlt_q, 1'b0}, i_rate_sel);
  // head unload: n*4ms = 16n ticks, zero gives 256 ticks
  wire [11:0] hut_ticks = scale((hut_q == 4'h0) ? 12'h100 :
                                {4'h0, hut_q, 4'h0}, i_rate_sel);

  // parameter byte counts per command
  function [1:0] nparams;
    input [4:0] o;
    begin
      case (o)
        `FCU_OP_SPECIFY:    nparams = 2'd2;
        `FCU_OP_DRV_STATUS: nparams = 2'd1;
        `FCU_OP_RECAL:      nparams = 2'd1;
        `FCU_OP_SEEK:       nparams = 2'd2;
        `FCU_OP_CONFIGURE:  nparams = 2'd3;
        default:            nparams = 2'd0;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // tick prescaler
  // --------------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_q <= 16'h0000;
    end else if (i_ce) begin
      tick_q <= tick ? TICK_CYC[15:0] - 16'h0001 : tick_q - 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // head load and unload timers
  // --------------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_head_load <= 1'b0;
      hld_q       <= 12'h000;
      hut_cnt_q   <= 12'h000;
    end else if (i_ce) begin
      if (i_xfer_need && !o_head_load) begin
        // load the head and wait before transfer starts
        o_head_load <= 1'b1;
        hld_q       <= hlt_ticks;
      end else if (tick && hld_q != 12'h000) begin
        hld_q <= hld_q - 12'h001;
      end
      if (i_xfer_done) begin
        hut_cnt_q <= hut_ticks;
      end else if (tick && hut_cnt_q != 12'h000) begin
        hut_cnt_q <= hut_cnt_q - 12'h001;
        if (hut_cnt_q == 12'h001) begin
          o_head_load <= 1'b0;
        end
      end
    end
  end

  assign o_head_ready = o_head_load && (hld_q == 12'h000);

  // --------------------------------------------------------------------------
  // transfer signalling: dma request or request_for_master plus interrupt
  // --------------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      xfer_q <= 1'b0;
    end else if (i_ce) begin
      xfer_q <= i_xfer_need && o_head_ready;
    end
  end

  assign o_dma_req            = xfer_q && !no_dma_q;
  assign o_request_for_master = (state_q == S_IDLE) || (xfer_q && no_dma_q);
  assign o_irq                = irq_q || (xfer_q && no_dma_q);
  assign o_busy               = (state_q == S_PARAM) || res_v_q;
  assign o_implied_seek_enable  = eis_q;
  assign o_fifo_disable_bit     = fifo_disable_bit_q;
  assign o_fifo_threshold_bytes = fifo_disable_bit_q ? 5'h01 : {1'b0, thr_q} + 5'h01;
  assign o_precomp_start_track  = precomp_start_track_q;

  // --------------------------------------------------------------------------
  // command sequencer
  // --------------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q     <= S_IDLE;
      op_q        <= 8'h00;
      pcnt_q      <= 2'd0;
      pidx_q      <= 2'd0;
      p1_q        <= 8'h00;
      p2_q        <= 8'h00;
      p3_q        <= 8'h00;
      srt_q       <= 4'h0;
      hut_q       <= 4'h0;
      hlt_q       <= 7'h00;
      no_dma_q    <= 1'b0;
      eis_q       <= `FCU_RST_EIS;
      fifo_disable_bit_q     <= `FCU_RST_FIFO_DISABLE_BIT;
      poll_off_q  <= `FCU_RST_POLL;
      thr_q       <= `FCU_RST_FIFO_THRESHOLD;
      precomp_start_track_q    <= `FCU_RST_PRECOMP_START_TRACK;
      pcn_q       <= 8'h00;
      steps_q     <= 8'h00;
      recal_q     <= 1'b0;
      rel_q       <= 1'b0;
      st0_q       <= 8'h00;
      irq_q       <= 1'b0;
      poll_done_q <= 1'b0;
      res_q       <= 8'h00;
      res_v_q     <= 1'b0;
      dly_q       <= 12'h000;
      pw_q        <= 8'h00;
      o_step      <= 1'b0;
      o_step_dir  <= 1'b0;
    end else if (i_ce) begin
      // single poll interrupt after reset, held off while head loaded
      if (!poll_done_q && !poll_off_q && hut_cnt_q == 12'h000 && !o_head_load) begin
        poll_done_q <= 1'b1;
        irq_q       <= 1'b1;
        st0_q       <= 8'hc0;
      end
      // result byte is consumed by a read
      if (i_rd && i_addr == `FCU_ADDR_RESULT) begin
        res_v_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (cmd_wr) begin
            op_q   <= i_wdata;
            pidx_q <= 2'd0;
            pcnt_q <= nparams(i_wdata[4:0]);
            state_q <= (nparams(i_wdata[4:0]) == 2'd0) ? S_EXEC : S_PARAM;
          end
        end
        S_PARAM: begin
          if (cmd_wr) begin
            case (pidx_q)
              2'd0:    p1_q <= i_wdata;
              2'd1:    p2_q <= i_wdata;
              default: p3_q <= i_wdata;
            endcase
            pidx_q <= pidx_q + 2'd1;
            if (pcnt_q == 2'd1) begin
              state_q <= S_EXEC;
            end
            pcnt_q <= pcnt_q - 2'd1;
          end
        end
        S_EXEC: begin
          state_q <= S_IDLE;
          case (opc)
            `FCU_OP_SPECIFY: begin
              srt_q    <= p1_q[7:4];
              hut_q    <= p1_q[3:0];
              hlt_q    <= p2_q[7:1];
              no_dma_q <= p2_q[0];
            end
            `FCU_OP_DRV_STATUS: begin
              // no execution phase: status 3 goes straight out
              res_q   <= {1'b0, i_write_prot, 1'b1, i_track_zero_sense,
                          1'b1, p1_q[2:0]};
              res_v_q <= 1'b1;
            end
            `FCU_OP_VERSION: begin
              res_q   <= VERSION_BYTE;
              res_v_q <= 1'b1;
            end
            `FCU_OP_CONFIGURE: begin
              eis_q      <= p2_q[`FCU_CFG_EIS_BIT];
              fifo_disable_bit_q    <= p2_q[`FCU_CFG_FIFO_DISABLE_BIT_BIT];
              poll_off_q <= p2_q[`FCU_CFG_POLL_BIT];
              thr_q      <= p2_q[3:0];
              precomp_start_track_q   <= p3_q;
            end
            `FCU_OP_SENSE_INT: begin
              res_q   <= st0_q;
              res_v_q <= 1'b1;
              irq_q   <= 1'b0;
            end
            `FCU_OP_RECAL: begin
              recal_q    <= 1'b1;
              pcn_q      <= 8'h00;
              steps_q    <= `FCU_RECAL_MAX;
              o_step_dir <= 1'b0;
              st0_q      <= {5'h00, p1_q[2:0]};
              state_q    <= i_track_zero_sense ? S_DONE : S_STEP;
              pw_q       <= `FCU_STEP_PULSE;
            end
            `FCU_OP_SEEK: begin
              recal_q <= 1'b0;
              st0_q   <= {5'h00, p1_q[2:0]};
              pw_q    <= `FCU_STEP_PULSE;
              if (op_q[`FCU_OPB_RELATIVE]) begin
                // one relative seek at a time; a second is dropped
                if (!rel_q) begin
                  rel_q      <= 1'b1;
                  o_step_dir <= op_q[`FCU_OPB_DIR];
                  steps_q    <= p2_q;
                  state_q    <= (p2_q == 8'h00) ? S_DONE : S_STEP;
                end
              end else begin
                o_step_dir <= (p2_q > pcn_q);
                steps_q    <= (p2_q > pcn_q) ? p2_q - pcn_q : pcn_q - p2_q;
                state_q    <= (p2_q == pcn_q) ? S_DONE : S_STEP;
              end
            end
            default: begin
              st0_q <= 8'h80;            // invalid command
            end
          endcase
        end
        S_STEP: begin
          // outward past track zero during relative seek faults
          if (rel_q && !o_step_dir && i_track_zero_sense) begin
            st0_q[`FCU_ST0_TF_BIT] <= 1'b1;
            st0_q[7:6]             <= 2'b01;
            state_q                <= S_DONE;
          end else begin
            o_step <= 1'b1;
            if (pw_q == 8'h00) begin
              o_step  <= 1'b0;
              steps_q <= steps_q - 8'h01;
              if (!recal_q) begin
                pcn_q <= o_step_dir ? pcn_q + 8'h01 : pcn_q - 8'h01;
              end
              // first gap may be short: counting starts mid tick
              dly_q   <= srt_ticks;
              state_q <= S_GAP;
            end else begin
              pw_q <= pw_q - 8'h01;
            end
          end
        end
        S_GAP: begin
          if (recal_q && i_track_zero_sense) begin
            state_q <= S_DONE;
          end else if (steps_q == 8'h00) begin
            if (recal_q) begin
              st0_q[`FCU_ST0_TF_BIT] <= 1'b1;
              st0_q[7:6]             <= 2'b01;
            end
            state_q <= S_DONE;
          end else if (tick) begin
            if (dly_q == 12'h001) begin
              pw_q    <= `FCU_STEP_PULSE;
              state_q <= S_STEP;
            end
            dly_q <= dly_q - 12'h001;
          end
        end
        S_DONE: begin
          st0_q[`FCU_ST0_SE_BIT] <= 1'b1;
          irq_q   <= 1'b1;
          rel_q   <= 1'b0;
          recal_q <= 1'b0;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // register read port, data one cycle after the strobe
  // --------------------------------------------------------------------------
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      if (i_rd) begin
        case (i_addr)
          `FCU_ADDR_RESULT: o_rdata <= res_q;
          `FCU_ADDR_STATUS: o_rdata <= {o_request_for_master, res_v_q, rel_q,
                                        irq_q, 4'h0};
          `FCU_ADDR_CONFIG: o_rdata <= {1'b0, eis_q, fifo_disable_bit_q, poll_off_q, thr_q};
          `FCU_ADDR_TIMING: o_rdata <= {srt_q, hut_q};
          `FCU_ADDR_CYL:    o_rdata <= pcn_q;
          default:          o_rdata <= 8'h00;
        endcase
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

endmodule

//--- include/fcu_defines.vh
// constants for the control command unit
`ifndef FCU_DEFINES_VH
`define FCU_DEFINES_VH
// ----------------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define FCU_ADDR_CMD       4'h0
`define FCU_ADDR_RESULT    4'h1
`define FCU_ADDR_STATUS    4'h2
`define FCU_ADDR_CONFIG    4'h3
`define FCU_ADDR_TIMING    4'h4
`define FCU_ADDR_CYL       4'h5
// ----------------------------------------------------------------------------
// command codes (low five bits of the opcode byte)
// ----------------------------------------------------------------------------
`define FCU_OP_SPECIFY     5'h03
`define FCU_OP_DRV_STATUS  5'h04
`define FCU_OP_RECAL       5'h07
`define FCU_OP_SENSE_INT   5'h08
`define FCU_OP_SEEK        5'h0f
`define FCU_OP_VERSION     5'h10
`define FCU_OP_CONFIGURE   5'h13
`define FCU_OPB_RELATIVE   7
`define FCU_OPB_DIR        6
// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define FCU_CFG_EIS_BIT    6
`define FCU_CFG_FIFO_DISABLE_BIT_BIT  5
`define FCU_CFG_POLL_BIT   4
`define FCU_RST_EIS        1'b0
`define FCU_RST_FIFO_DISABLE_BIT      1'b1
`define FCU_RST_POLL       1'b0
`define FCU_RST_FIFO_THRESHOLD    4'h0
`define FCU_RST_PRECOMP_START_TRACK     8'h00
`define FCU_ST0_SE_BIT     5
`define FCU_ST0_TF_BIT     4
`define FCU_RECAL_MAX      8'h50
// ----------------------------------------------------------------------------
// timing: base unit is 0.25 ms at the fastest rate
// ----------------------------------------------------------------------------
`define FCU_CLK_MHZ        50
`define FCU_TICK_US        250
`define FCU_TICK_CYC       (`FCU_TICK_US * `FCU_CLK_MHZ)
`define FCU_STEP_PULSE     8'h0a
`endif

//--- tb/fcu_sva.sv
// assertion checker for the control command unit
`timescale 1ns/10ps
module fcu_sva (
  input wire       i_clk,
  input wire       i_rst_n,
  input wire       i_rd,
  input wire       i_xfer_need,
  input wire [7:0] o_rdata,
  input wire       o_step,
  input wire       o_step_dir,
  input wire       o_head_load,
  input wire       o_head_ready,
  input wire       o_dma_req,
  input wire       o_irq,
  input wire       o_implied_seek_enable,
  input wire       o_fifo_disable_bit,
  input wire [4:0] o_fifo_threshold_bytes,
  input wire [7:0] o_precomp_start_track
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  // one step pulse, ten cycles high then low
  sequence s_pulse;
    o_step [*8] ##1 o_step [*2] ##1 !o_step;
  endsequence
  // feature settings as they come out of reset
  sequence s_defaults;
    o_fifo_disable_bit && !o_implied_seek_enable &&
      (o_fifo_threshold_bytes == 5'h01) && (o_precomp_start_track == 8'h00);
  endsequence
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_reset_defaults: assert property ($rose(i_rst_n) |-> s_defaults)
    else $error("feature defaults wrong after reset");
  a_poll_irq: assert property ($rose(i_rst_n) |-> ##[0:300] o_irq)
    else $error("no poll interrupt after reset");
  a_step_width: assert property ($rose(o_step) |-> s_pulse)
    else $error("step pulse width wrong");
  a_dir_hold: assert property (o_step && $past(o_step) |-> $stable(o_step_dir))
    else $error("direction moved during step");
  a_fifo_off: assert property (o_fifo_disable_bit |-> o_fifo_threshold_bytes == 5'h01)
    else $error("threshold not one with fifo off");
  a_thr_range: assert property (o_fifo_threshold_bytes >= 5'h01 &&
                                o_fifo_threshold_bytes <= 5'h10)
    else $error("threshold out of range");
  a_head_ready: assert property (o_head_ready |-> o_head_load)
    else $error("head ready without head load");
  a_dma_cause: assert property (o_dma_req |-> $past(i_xfer_need))
    else $error("dma request without transfer");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule

bind fcu_control_unit fcu_sva u_fcu_sva (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_rd(i_rd), .i_xfer_need(i_xfer_need),
  .o_rdata(o_rdata), .o_step(o_step), .o_step_dir(o_step_dir),
  .o_head_load(o_head_load), .o_head_ready(o_head_ready), .o_dma_req(o_dma_req),
  .o_irq(o_irq), .o_implied_seek_enable(o_implied_seek_enable),
  .o_fifo_disable_bit(o_fifo_disable_bit),
  .o_fifo_threshold_bytes(o_fifo_threshold_bytes),
  .o_precomp_start_track(o_precomp_start_track));

//--- tb/fcu_drive_model.sv
// behavioural drive mechanism: head position, step input, track zero line
`timescale 1ns/10ps
module fcu_drive_model (
  input  wire        i_clk,
  input  wire        i_step,
  input  wire        i_step_dir,
  output wire        o_track_zero_sense,
  output reg  [15:0] o_step_count,
  output reg  [15:0] o_pos
);
  reg step_q = 1'b0;  // last step level
  // head position survives a controller reset, as a real mechanism does
  initial o_pos = 16'h0000;
  initial o_step_count = 16'h0000;
  // sensor sees only the physical position
  assign o_track_zero_sense = (o_pos == 16'h0000);
  // move one track on every rising step edge, except outward at track zero
  always @(posedge i_clk) begin
    step_q <= i_step;
    if (i_step && !step_q) begin
      o_step_count <= o_step_count + 16'h0001;
      if (i_step_dir) begin
        o_pos <= o_pos + 16'h0001;
      end else if (o_pos != 16'h0000) begin
        o_pos <= o_pos - 16'h0001;
      end
    end
  end
endmodule

//--- tb/tb_top.sv
// self-checking testbench for the control command unit
`timescale 1ns/10ps
module tb_top;
  localparam [7:0] VER = 8'h3c;  // arbitrary identity value
  reg        i_clk = 1'b0;
  reg        i_rst_n = 1'b0;
  reg [3:0]  i_addr = 4'h0;
  reg [7:0]  i_wdata = 8'h00;
  reg        i_wr = 1'b0;
  reg        i_rd = 1'b0;
  reg [1:0]  i_rate_sel = 2'h0;
  reg        i_write_prot = 1'b0;
  reg        i_xfer_need = 1'b0;
  reg        i_xfer_done = 1'b0;
  wire [7:0] o_rdata;
  wire       o_step, o_step_dir, o_head_load, o_head_ready, o_dma_req, o_irq;
  wire       o_request_for_master, o_implied_seek_enable, o_fifo_disable_bit, o_busy;
  wire [4:0] o_fifo_threshold_bytes;
  wire [7:0] o_precomp_start_track;
  wire       tz;
  wire [15:0] steps, pos;
  integer    fail_count = 0;
  integer    checks = 0;
  integer    i, n, t;
  reg        rd_q = 1'b0;
  reg [7:0]  exp_q[$];
  reg [7:0]  msk_q[$];
  reg [7:0]  r, p;
  reg [15:0] s0;
  always #10 i_clk = ~i_clk;
  fcu_control_unit #(.TICK_CYC(4), .VERSION_BYTE(VER)) u_fcu_control_unit (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rate_sel(i_rate_sel),
    .i_track_zero_sense(tz), .i_write_prot(i_write_prot), .i_xfer_done(i_xfer_done),
    .i_xfer_need(i_xfer_need), .o_step(o_step), .o_step_dir(o_step_dir),
    .o_head_load(o_head_load), .o_head_ready(o_head_ready), .o_dma_req(o_dma_req),
    .o_request_for_master(o_request_for_master), .o_irq(o_irq),
    .o_implied_seek_enable(o_implied_seek_enable), .o_fifo_disable_bit(o_fifo_disable_bit),
    .o_fifo_threshold_bytes(o_fifo_threshold_bytes),
    .o_precomp_start_track(o_precomp_start_track), .o_busy(o_busy));
  fcu_drive_model u_fcu_drive_model (.i_clk(i_clk), .i_step(o_step), .i_step_dir(o_step_dir),
    .o_track_zero_sense(tz), .o_step_count(steps), .o_pos(pos));
  // ---------------------------------------------------------------
  // reporting and comparison
  // ---------------------------------------------------------------
  task give_verdict;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] exp, input [15:0] got);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // read data stand one cycle after the strobe; take the oldest note then
  always @(posedge i_clk) begin
    if (rd_q) chk("rdata", exp_q.pop_front(), o_rdata & msk_q.pop_front());
    rd_q <= i_rd;
  end
  // ---------------------------------------------------------------
  // bus and command tasks
  // ---------------------------------------------------------------
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge i_clk);
      i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e, input [7:0] m);
    begin
      @(posedge i_clk);
      i_rd <= 1'b1; i_addr <= a;
      exp_q.push_back(e & m); msk_q.push_back(m);
      @(posedge i_clk);
      i_rd <= 1'b0;
    end
  endtask
  // bounded wait for the seek or poll interrupt
  task wait_irq;
    begin
      n = 0;
      while (o_irq !== 1'b1 && n < 40000) begin @(posedge i_clk); n = n + 1; end
      if (n >= 40000) begin fail_count = fail_count + 1; give_verdict; end
      repeat (2) @(posedge i_clk);
    end
  endtask
  task sense(input [7:0] e, input [7:0] m);
    begin
      wr(4'h0, 8'h08); repeat (2) @(posedge i_clk); rd(4'h1, e, m);
    end
  endtask
  task relseek(input dir, input [7:0] cnt);
    begin
      s0 = steps;
      wr(4'h0, {1'b1, dir, 6'h0f}); wr(4'h0, 8'h00); wr(4'h0, cnt); wait_irq;
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    r = $urandom(32'hc7891bf0);
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1; i_rate_sel <= $urandom; i_write_prot <= $urandom;
    @(negedge i_clk);
    chk("fifo_off", 16'h1, o_fifo_disable_bit);
    chk("thr", 16'h1, o_fifo_threshold_bytes);
    chk("eis", 16'h0, o_implied_seek_enable);
    chk("precomp_start_track", 16'h0, o_precomp_start_track);
    wait_irq; sense(8'hc0, 8'hff);
    @(negedge i_clk); chk("irq_clr", 16'h0, o_irq);
    wr(4'h0, 8'h10); repeat (2) @(posedge i_clk); rd(4'h1, VER, 8'hff);
    wr(4'h0, 8'h04); wr(4'h0, 8'h00); repeat (2) @(posedge i_clk);
    rd(4'h2, 8'h40, 8'h40); rd(4'h1, {1'b0, i_write_prot, 6'h38}, 8'hff);
    for (i = 0; i < 4; i = i + 1) begin
      r = $urandom; p = $urandom;
      if (i == 0) begin r = 8'h4f; p = 8'hff; end
      wr(4'h0, 8'h13); wr(4'h0, 8'h00); wr(4'h0, {1'b0, r[6:5], 1'b0, r[3:0]}); wr(4'h0, p);
      repeat (2) @(posedge i_clk); @(negedge i_clk);
      chk("eis", r[6], o_implied_seek_enable);
      chk("fifo_off", r[5], o_fifo_disable_bit);
      chk("thr", r[5] ? 16'h1 : r[3:0] + 16'h1, o_fifo_threshold_bytes);
      chk("precomp_start_track", p, o_precomp_start_track);
    end
    for (i = 0; i < 2; i = i + 1) begin
      r = $urandom;
      wr(4'h0, 8'h03); wr(4'h0, {4'hf, r[3:0]}); wr(4'h0, {r[7:1], i[0]});
      repeat (2) @(posedge i_clk); rd(4'h4, {4'hf, r[3:0]}, 8'hff);
      i_xfer_need <= 1'b1; n = 0;
      while (!o_head_ready && n < 9000) begin @(posedge i_clk); n = n + 1; end
      t = (r[7:1] == 7'h00 ? 256 : 2 * r[7:1]) << i_rate_sel;
      if (i == 0) chk("hlt", 16'h1, n >= 4 * t - 4 && n <= 4 * t + 4);
      if (n >= 9000) give_verdict;
      repeat (3) @(posedge i_clk); @(negedge i_clk);
      chk("dma_req", !i[0], o_dma_req);
      if (i[0]) chk("rqm", 16'h1, o_request_for_master);
      chk("irq", i[0], o_irq);
      @(posedge i_clk); i_xfer_need <= 1'b0; repeat (3) @(posedge i_clk);
    end
    // end of a transfer starts the unload delay; head drops when it expires
    i_xfer_done <= 1'b1; @(posedge i_clk); i_xfer_done <= 1'b0; n = 0;
    while (o_head_load && n < 9000) begin @(posedge i_clk); n = n + 1; end
    t = (r[3:0] == 4'h0 ? 256 : 16 * r[3:0]) << i_rate_sel;
    chk("hut", 16'h1, n >= 4 * t - 4 && n <= 4 * t + 4);
    if (n >= 9000) give_verdict;
    relseek(1'b0, 8'h05); sense(8'h10, 8'h10);
    chk("steps", s0, steps);
    relseek(1'b1, 8'hc8); sense(8'h20, 8'h30);
    chk("steps", s0 + 16'd200, steps);
    chk("pos", 16'd200, pos);
    relseek(1'b1, 8'h64); sense(8'h20, 8'h30);
    chk("steps", s0 + 16'd100, steps);
    rd(4'h5, 8'd44, 8'hff);
    s0 = steps; wr(4'h0, 8'h07); wr(4'h0, 8'h00); wait_irq; sense(8'h30, 8'h30);
    chk("steps", s0 + 16'd80, steps);
    chk("pos", 16'd220, pos);
    s0 = steps; wr(4'h0, 8'h0f); wr(4'h0, 8'h00); wr(4'h0, 8'h05);
    wait_irq; sense(8'h20, 8'hf0);
    chk("steps", s0 + 16'd5, steps);
    rd(4'h5, 8'h05, 8'hff);
    repeat (4) @(posedge i_clk);
    give_verdict;
  end
endmodule
